/* File: core/rcw_consts.svh */
// Constants for the runaway code watchdog: register indices, field
// positions, reset values and slow-clock tick counts.
// Assumes a 32-bit AXI4-Lite slave, byte address = 4 * index.
//
// Overview of operation
// - A 12-bit prescaler on the slow clock feeds a 6-bit main counter.
// - Counter overflow without a clear issues a reset after 2^18-16 or 2^13-16 ticks.
// - Rate select 1 gives 2^13-16 ticks, 0 gives 2^18-16; reset clears it.
// - Any write to the clear register clears counter and prescaler bits 11:4.
// - Reading the clear register returns the reset vector low byte.
// - Expiry drives the reset pin low 32 slow ticks and sets the cause flag.
// - A stop instruction clears the prescaler.
// - Power-on logic clears the prescaler 4096 slow ticks after power-up.
// - Any internal reset clears prescaler and main counter.
// - A reset vector fetch clears the prescaler.
// - Disable bit 1 keeps the watchdog off; 0 enables it.
// - The watchdog never raises an interrupt; expiry only resets.
// - Monitor entry with test voltage on irq pin disables while voltage stays.
// - Monitor entry by blank vectors disables until the next power-on reset.
// - Break with test voltage on the reset pin holds the watchdog off.
// - Wait mode keeps the watchdog counting.
// - Stop mode halts the slow clock to the watchdog and clears the prescaler.
// - With stop disabled, a stop instruction is an illegal opcode reset.
// - The watchdog runs from the slow internal clock, about 47 kHz.
`ifndef RCW_CONSTS_SVH
`define RCW_CONSTS_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define RCW_IDX_CLEAR 16'hffff
`define RCW_IDX_CONFIG 16'h0001
`define RCW_IDX_SOURCE 16'h0002
`define RCW_IDX_STATUS 16'h0003

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define RCW_CFG_RATE_BIT 0
`define RCW_CFG_DIS_BIT 1
`define RCW_CFG_STOPDIS_BIT 2
`define RCW_SRC_WDOG_BIT 0
`define RCW_CFG_RESET 3'h0

// ****************************************************************
// Slow clock rate and timing in slow clock ticks
// ****************************************************************
`define RCW_SLOW_HZ 47000
`define RCW_PULSE_TICKS 6'h20
`define RCW_POR_TICKS 4096
`define RCW_PRESC_LIMIT 12'hff0
`define RCW_CNT_LONG 6'h3f

`endif

/* File: core/rcw_pkg.sv */
// Types shared by the runaway code watchdog.
// Assumes the constants header is included by the design file.
package rcw_pkg;

  // Watchdog sequencing
  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_PULSE
  } rcw_state_e;

  // Configuration register one fields
  typedef struct packed {
    logic stop_disable;
    logic watchdog_disable;
    logic timeout_rate_select;
  } rcw_cfg_s;

  // AXI response codes
  typedef logic [1:0] rcw_resp_t;

endpackage

/* File: core/rcw_top.sv */
// Runaway code watchdog with AXI4-Lite register access.
// Assumes one clock aclk; the slow clock and test voltage detectors
// arrive as asynchronous pins; mode and fetch strobes are aclk logic.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`include "rcw_consts.svh"

module rcw_top #(
  parameter int POR_TICKS = `RCW_POR_TICKS
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [17:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output rcw_pkg::rcw_resp_t bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [17:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output rcw_pkg::rcw_resp_t rresp,
  // Asynchronous pins
  input wire logic internal_slow_clock,
  input wire logic test_high_voltage_irq,
  input wire logic test_high_voltage_rst,
  // CPU and system state, aclk domain
  input wire logic stop_mode,
  input wire logic stop_exec,
  input wire logic reset_vector_fetch,
  input wire logic internal_reset,
  input wire logic monitor_mode,
  input wire logic break_active,
  input wire logic [7:0] reset_vector_low,
  // Open-drain reset pin and reset requests
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic watchdog_reset,
  output logic illegal_stop_reset,
  output logic watchdog_cause,
  output rcw_pkg::rcw_cfg_s config_out
);
  import rcw_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic aw_v_r;
  logic [15:0] aw_i_r;
  logic w_v_r;
  logic [31:0] w_d_r;
  logic [3:0] w_s_r;
  logic bvalid_r;
  rcw_resp_t bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  rcw_resp_t rresp_r;
  rcw_cfg_s cfg_r;
  logic cause_r;
  logic clear_pend_r;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic slow_prev_r;
  logic [11:0] presc_r;
  logic [5:0] cnt_r;
  logic [5:0] pulse_r;
  rcw_state_e state_r;
  rcw_state_e state_nxt;
  logic [12:0] por_cnt_r;
  logic por_done_r;
  logic mon_prev_r;
  logic entry_hv_r;
  logic blank_lock_r;
  logic illegal_r;
  logic disabled;
  logic fire;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Write needs both halves and a free response slot
  wire do_wr = aw_v_r & w_v_r & ~bvalid_r;
  wire do_rd = arvalid & ~rvalid_r;
  wire [15:0] ar_idx = araddr[17:2];
  wire wr_clear = do_wr & (aw_i_r == `RCW_IDX_CLEAR);
  wire wr_cfg = do_wr & (aw_i_r == `RCW_IDX_CONFIG) & w_s_r[0];
  wire wr_src = do_wr & (aw_i_r == `RCW_IDX_SOURCE) & w_s_r[0];
  wire wr_hit = (aw_i_r == `RCW_IDX_CLEAR) | (aw_i_r == `RCW_IDX_CONFIG) |
                (aw_i_r == `RCW_IDX_SOURCE) | (aw_i_r == `RCW_IDX_STATUS);
  wire rd_hit = (ar_idx == `RCW_IDX_CLEAR) | (ar_idx == `RCW_IDX_CONFIG) |
                (ar_idx == `RCW_IDX_SOURCE) | (ar_idx == `RCW_IDX_STATUS);

  // Read multiplexer; the clear index shows the vector byte, not state
  wire [31:0] rd_status = {21'h0, blank_lock_r, state_r == ST_PULSE,
                           disabled, 2'h0, cnt_r};
  wire [31:0] rd_mux =
    (ar_idx == `RCW_IDX_CLEAR) ? {24'h0, reset_vector_low} :
    (ar_idx == `RCW_IDX_CONFIG) ? {29'h0, cfg_r} :
    (ar_idx == `RCW_IDX_SOURCE) ? {31'h0, cause_r} :
    (ar_idx == `RCW_IDX_STATUS) ? rd_status : 32'h0;

  assign awready = ~aw_v_r;
  assign wready = ~w_v_r;
  assign arready = ~rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Address and data are captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_r <= 1'b0;
      aw_i_r <= 16'h0;
      w_v_r <= 1'b0;
      w_d_r <= 32'h0;
      w_s_r <= 4'h0;
    end else if (clk_en) begin
      if (awvalid && !aw_v_r) begin
        aw_v_r <= 1'b1;
        aw_i_r <= awaddr[17:2];
      end else if (do_wr) begin
        aw_v_r <= 1'b0;
      end
      if (wvalid && !w_v_r) begin
        w_v_r <= 1'b1;
        w_d_r <= wdata;
        w_s_r <= wstrb;
      end else if (do_wr) begin
        w_v_r <= 1'b0;
      end
    end
  end

  // Write response; unmapped index answers SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
    end else if (clk_en) begin
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? 2'h0 : 2'h2;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel, one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end else if (clk_en) begin
      if (do_rd) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? 2'h0 : 2'h2;
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Configuration and cause flag
  // ****************************************************************
  // Reset clears rate select, disable and stop disable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= `RCW_CFG_RESET;
    end else if (clk_en && wr_cfg) begin
      cfg_r <= w_d_r[2:0];
    end
  end

  // Expiry sets the cause flag; a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_r <= 1'b0;
    end else if (clk_en) begin
      if (fire) begin
        cause_r <= 1'b1;
      end else if (wr_src && w_d_r[`RCW_SRC_WDOG_BIT]) begin
        cause_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Pin synchronisers and slow clock tick
  // ****************************************************************
  // Two flops per pin; only sync2 feeds logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      slow_prev_r <= 1'b0;
    end else if (clk_en) begin
      sync1_r <= {test_high_voltage_rst, test_high_voltage_irq, internal_slow_clock};
      sync2_r <= sync1_r;
      slow_prev_r <= sync2_r[0];
    end
  end

  wire slow_tick = sync2_r[0] & ~slow_prev_r;
  wire hv_irq = sync2_r[1];
  wire hv_rst = sync2_r[2];

  // ****************************************************************
  // Disable sources
  // ****************************************************************
  // Config bit, monitor mode locks and break with test voltage
  assign disabled = cfg_r.watchdog_disable |
                  (monitor_mode & entry_hv_r & (hv_irq | hv_rst)) |
                  blank_lock_r |
                  (break_active & hv_rst);

  // Monitor entry kind is caught at the entry edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_prev_r <= 1'b0;
      entry_hv_r <= 1'b0;
      blank_lock_r <= 1'b0;
    end else if (clk_en) begin
      mon_prev_r <= monitor_mode;
      if (monitor_mode && !mon_prev_r) begin
        entry_hv_r <= hv_irq;
        if (!hv_irq) begin
          blank_lock_r <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Power-on prescaler clear
  // ****************************************************************
  // aresetn stands for power-on; one clear after POR_TICKS slow ticks
  wire por_clear = slow_tick & ~por_done_r &
                   (por_cnt_r == 13'(POR_TICKS - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt_r <= 13'h0;
      por_done_r <= 1'b0;
    end else if (clk_en && slow_tick && !por_done_r) begin
      por_cnt_r <= por_cnt_r + 13'h1;
      por_done_r <= por_clear;
    end
  end

  // ****************************************************************
  // Prescaler and main counter
  // ****************************************************************
  // Stop gates the slow clock; wait mode does not gate it
  wire cnt_tick = slow_tick & ~stop_mode;
  wire stop_ok = stop_exec & ~cfg_r.stop_disable;
  wire at_limit = (presc_r == `RCW_PRESC_LIMIT) &
                  (cfg_r.timeout_rate_select ? cnt_r[0] :
                   (cnt_r == `RCW_CNT_LONG));
  assign fire = (state_r == ST_RUN) & ~disabled & at_limit;
  wire cnt_clr = internal_reset | fire | (state_r == ST_PULSE) | disabled;
  wire presc_clr = cnt_clr | stop_mode | stop_ok |
                   reset_vector_fetch | por_clear;
  // Bus clear acts only on a slow tick, as the slow domain would
  wire apply_clr = clear_pend_r & slow_tick;

  // Clear request pending; a new write in the applying cycle stays
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_pend_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_clear) begin
        clear_pend_r <= 1'b1;
      end else if (apply_clr) begin
        clear_pend_r <= 1'b0;
      end
    end
  end

  // 12-bit prescaler carrying into the 6-bit counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= 12'h0;
      cnt_r <= 6'h0;
    end else if (clk_en) begin
      if (presc_clr) begin
        presc_r <= 12'h0;
      end else if (apply_clr) begin
        presc_r <= {8'h0, presc_r[3:0]};
      end else if (cnt_tick) begin
        presc_r <= presc_r + 12'h1;
      end
      if (cnt_clr || apply_clr) begin
        cnt_r <= 6'h0;
      end else if (cnt_tick && !presc_clr && presc_r == 12'hfff) begin
        cnt_r <= cnt_r + 6'h1;
      end
    end
  end

  // ****************************************************************
  // Reset pulse sequencing
  // ****************************************************************
  // Next state; the pulse always runs its full length
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (!disabled) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (disabled) begin
          state_nxt = ST_OFF;
        end else if (at_limit) begin
          state_nxt = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (slow_tick && pulse_r == `RCW_PULSE_TICKS - 6'h1) begin
          state_nxt = disabled ? ST_OFF : ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  // State and pulse length counter in slow ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_OFF;
      pulse_r <= 6'h0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (state_r != ST_PULSE) begin
        pulse_r <= 6'h0;
      end else if (slow_tick) begin
        pulse_r <= pulse_r + 6'h1;
      end
    end
  end

  // Illegal stop is reported as a one-cycle reset request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      illegal_r <= 1'b0;
    end else if (clk_en) begin
      illegal_r <= stop_exec & cfg_r.stop_disable;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // No interrupt output exists; expiry acts only as a reset
  assign watchdog_reset = (state_r == ST_PULSE);
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = (state_r == ST_PULSE);
  assign illegal_stop_reset = illegal_r;
  assign watchdog_cause = cause_r;
  assign config_out = cfg_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_fire;
    fire && clk_en;
  endsequence

  sequence s_pulse_on;
    state_r == ST_PULSE && rst_pin_oe && !rst_pin_out;
  endsequence

  chk_pulse_start: assert property (s_fire |=> s_pulse_on)
    else $error("expiry did not start the reset pulse");
  chk_cause_set: assert property (s_fire |=> cause_r)
    else $error("cause flag not set on expiry");
  chk_long_limit: assert property (fire && !cfg_r.timeout_rate_select |->
    cnt_r == 6'h3f && presc_r == 12'hff0)
    else $error("long timeout fired at wrong count");
  chk_short_limit: assert property (fire && cfg_r.timeout_rate_select |->
    cnt_r[0] && presc_r == 12'hff0)
    else $error("short timeout fired at wrong count");
  chk_disable_holds: assert property (disabled && clk_en |=>
    presc_r == 12'h0 && cnt_r == 6'h0 && state_r != ST_RUN)
    else $error("disabled watchdog kept counting");
  chk_stop_halts: assert property (stop_mode && clk_en |=> presc_r == 12'h0)
    else $error("prescaler not cleared in stop mode");
  chk_write_clears: assert property (apply_clr && clk_en && !presc_clr |=>
    cnt_r == 6'h0 && presc_r[11:4] == 8'h0)
    else $error("clear write did not clear counters");
  chk_int_reset: assert property (internal_reset && clk_en |=>
    presc_r == 12'h0 && cnt_r == 6'h0)
    else $error("internal reset left counters running");
  chk_read_vector: assert property (do_rd && clk_en && ar_idx == 16'hffff |=>
    rdata_r == {24'h0, $past(reset_vector_low)})
    else $error("clear register read did not return vector byte");
  chk_illegal_stop: assert property (stop_exec && cfg_r.stop_disable && clk_en |=>
    illegal_stop_reset)
    else $error("disabled stop did not request reset");

endmodule

/* File: bench/rcw_far_end.sv */
// Far-side model for the watchdog: free-running slow oscillator and
// the reset pin wire. Assumes the watchdog only ever pulls the pin low.
`timescale 1ns/100ps
module rcw_far_end #(
  parameter real HALF_NS = 31.0
) (
  // Slow oscillator
  output logic slow_clk,
  // Open-drain reset pin
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic rst_pin_n
);
  // Oscillator never stops, phase unrelated to aclk
  initial slow_clk = 1'b0;
  always #(HALF_NS) slow_clk = ~slow_clk;
  // Pull-up holds the pin high whenever nobody drives it
  assign rst_pin_n = pin_oe ? pin_out : 1'b1;
endmodule

/* File: bench/runaway_code_watchdog_tb_top.sv */
// Self-checking bench for the watchdog top level.
// Assumes the constants header and package are compiled first.
`timescale 1ns/100ps
`include "rcw_consts.svh"
module runaway_code_watchdog_tb_top;
  import rcw_pkg::*;
  // ****
  // Setup
  // ****
  localparam int P = 62;
  localparam logic [17:0] A_CLR = {`RCW_IDX_CLEAR, 2'b00};
  localparam logic [17:0] A_CFG = {`RCW_IDX_CONFIG, 2'b00};
  localparam logic [17:0] A_SRC = {`RCW_IDX_SOURCE, 2'b00};
  localparam logic [17:0] A_STA = {`RCW_IDX_STATUS, 2'b00};
  localparam logic [17:0] A_BAD = 18'h00040;
  localparam logic [7:0] VEC_LO = 8'h5a;
  logic aclk, aresetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, slow_clk, tst_irq, tst_rst;
  logic stop_mode, stop_exec, vec_fetch, int_rst, monitor_mode, break_active;
  logic pin_out, pin_oe, rst_pin_n, watchdog_reset, illegal_stop_reset, watchdog_cause;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  rcw_resp_t bresp, rresp;
  rcw_cfg_s config_out;
  int bad_count, n_tests;

  // Short power-on count keeps the run brief
  rcw_top #(.POR_TICKS(4)) u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .internal_slow_clock(slow_clk), .test_high_voltage_irq(tst_irq),
    .test_high_voltage_rst(tst_rst), .stop_mode(stop_mode), .stop_exec(stop_exec),
    .reset_vector_fetch(vec_fetch), .internal_reset(int_rst),
    .monitor_mode(monitor_mode), .break_active(break_active),
    .reset_vector_low(VEC_LO), .rst_pin_out(pin_out), .rst_pin_oe(pin_oe),
    .watchdog_reset(watchdog_reset), .illegal_stop_reset(illegal_stop_reset),
    .watchdog_cause(watchdog_cause), .config_out(config_out));
  rcw_far_end #(.HALF_NS(P / 2.0)) u_far (.slow_clk(slow_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .rst_pin_n(rst_pin_n));

  // 100 MHz clock
  always #5 aclk = ~aclk;

  // ****
  // Helpers
  // ****
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic timeout;
    bad_count++;
    $display("ERROR t=%0t wait limit reached", $time);
    summarize();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Handshakes are judged at the rising edge; each channel drops once taken
  task automatic wr(input logic [17:0] a, input logic [31:0] d, output rcw_resp_t r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    timeout();
  endtask

  task automatic rd(input logic [17:0] a, output logic [31:0] d, output rcw_resp_t r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    timeout();
  endtask

  task automatic rsta(output logic [31:0] d);
    rcw_resp_t r;
    wt(5);
    rd(A_STA, d, r);
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    logic [31:0] d;
    rcw_resp_t r;
    rd(A_CFG, d, r);
    chk(d, 32'h0);
    wr(A_CLR, 32'hffffffff, r);
    rd(A_CLR, d, r);
    chk(d, {24'h0, VEC_LO});
    wr(A_BAD, 32'h1, r);
    chk({30'h0, r}, 32'h2);
    rd(A_BAD, d, r);
    chk({30'h0, r}, 32'h2);
    $display("test regs done");
  endtask

  task automatic t_dis;
    logic [31:0] d;
    rcw_resp_t r;
    wr(A_CFG, 32'h2, r);
    chk({29'h0, config_out}, 32'h2);
    rsta(d);
    chk({31'h0, d[8]}, 32'h1);
    wr(A_CFG, 32'h0, r);
    rsta(d);
    chk({31'h0, d[8]}, 32'h0);
    $display("test disable done");
  endtask

  // Monitor entry with and without test voltage, then a break
  task automatic t_mon;
    logic [31:0] d;
    tst_irq <= 1'b1;
    wt(5);
    monitor_mode <= 1'b1;
    rsta(d);
    chk({31'h0, d[8]}, 32'h1);
    tst_irq <= 1'b0;
    rsta(d);
    chk({31'h0, d[8]}, 32'h0);
    monitor_mode <= 1'b0;
    wt(2);
    monitor_mode <= 1'b1;
    rsta(d);
    chk({31'h0, d[10]}, 32'h1);
    monitor_mode <= 1'b0;
    rsta(d);
    chk({31'h0, d[8]}, 32'h1);
    do_reset();
    rsta(d);
    chk({31'h0, d[8]}, 32'h0);
    break_active <= 1'b1;
    tst_rst <= 1'b1;
    rsta(d);
    chk({31'h0, d[8]}, 32'h1);
    break_active <= 1'b0;
    tst_rst <= 1'b0;
    rsta(d);
    chk({31'h0, d[8]}, 32'h0);
    $display("test monitor done");
  endtask

  task automatic t_stop;
    rcw_resp_t r;
    int k;
    for (k = 1; k >= 0; k--) begin
      wr(A_CFG, (k == 1) ? 32'h4 : 32'h0, r);
      @(posedge aclk);
      stop_exec <= 1'b1;
      @(posedge aclk);
      stop_exec <= 1'b0;
      @(negedge aclk);
      chk({31'h0, illegal_stop_reset}, k);
      @(negedge aclk);
      chk({31'h0, illegal_stop_reset}, 32'h0);
    end
    $display("test stop done");
  endtask

  // Stop holds and internal reset clears the main counter; a vector fetch starts no reset pulse
  task automatic t_hold;
    logic [31:0] d;
    stop_mode <= 1'b1;
    rsta(d);
    chk({26'h0, d[5:0]}, 32'h0);
    stop_mode <= 1'b0;
    int_rst <= 1'b1;
    wt(3);
    int_rst <= 1'b0;
    rsta(d);
    chk({26'h0, d[5:0]}, 32'h0);
    vec_fetch <= 1'b1;
    wt(1);
    vec_fetch <= 1'b0;
    rsta(d);
    chk({31'h0, d[9]}, 32'h0);
    $display("test hold done");
  endtask

  // Short timeout from a clear, then the reset pulse and cause flag
  task automatic t_exp;
    logic [31:0] d;
    rcw_resp_t r;
    time t0, t1;
    int i;
    wr(A_CFG, 32'h1, r);
    wr(A_CLR, 32'h0, r);
    t0 = $time;
    for (i = 0; i < 60000 && rst_pin_n; i++) @(negedge aclk);
    if (i == 60000) timeout();
    t1 = $time;
    chk({31'h0, (t1 - t0 >= 8159 * P) && (t1 - t0 <= 8178 * P + 100)}, 1);
    chk({31'h0, watchdog_cause}, 32'h1);
    chk({31'h0, watchdog_reset}, 32'h1);
    t0 = $time;
    for (i = 0; i < 1000 && !rst_pin_n; i++) @(negedge aclk);
    if (i == 1000) timeout();
    t1 = $time;
    chk({31'h0, (t1 - t0 >= 31 * P) && (t1 - t0 <= 33 * P)}, 1);
    rd(A_SRC, d, r);
    chk(d, 32'h1);
    wr(A_SRC, 32'h1, r);
    rd(A_SRC, d, r);
    chk(d, 32'h0);
    $display("test expiry done");
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {tst_irq, tst_rst, stop_mode, stop_exec, vec_fetch, int_rst} = '0;
    {monitor_mode, break_active, awaddr, araddr, wdata} = '0;
    clk_en = 1'b1;
    wstrb = 4'hf;
    bad_count = 0;
    n_tests = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_dis();
    t_mon();
    t_stop();
    t_hold();
    t_exp();
    summarize();
  end
endmodule
